// ---- design/hsu_regs.vh ----
`ifndef HSU_REGS_VH
`define HSU_REGS_VH

// primary opcodes, instruction bits 0-5
`define HSU_OP_STH_UPD 6'h2d
`define HSU_OP_EXT 6'h1f
`define HSU_OP_STM_WORD 6'h2f

// extended opcodes, instruction bits 21-30
`define HSU_XO_STH_UPD_X 10'h1b7
`define HSU_XO_STH_X 10'h197

// field positions, big-endian bit n sits at vector index 31-n
`define HSU_F_OPCD 31:26
`define HSU_F_SRC 25:21
`define HSU_F_BASE 20:16
`define HSU_F_INDEX 15:11
`define HSU_F_XO 10:1
`define HSU_F_DISP 15:0
`define HSU_F_HALF 15:0

// decoded instruction classes
`define HSU_CLS_NONE 3'h0
`define HSU_CLS_D_UPD 3'h1
`define HSU_CLS_X_UPD 3'h2
`define HSU_CLS_X_PLAIN 3'h3
`define HSU_CLS_MULT 3'h4

// memory access size codes
`define HSU_SIZE_HALF 2'h1
`define HSU_SIZE_WORD 2'h2

// last register of a multiple store, word stride
`define HSU_LAST_REG 5'h1f
`define HSU_WORD_STEP 32'h0000_0004

// fault cause bits
`define HSU_FAULT_ALIGN 2'h1
`define HSU_FAULT_DSI 2'h2

`endif

// ---- design/hsu_gpr_file.v ----
`timescale 1ns/100ps
// general-purpose register array, one write and one registered read port
module hsu_gpr_file #(
	parameter DEPTH = 32,
	parameter IDX_W = 5
) (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// write port
	input wire wr_en,
	input wire [IDX_W-1:0] wr_idx,
	input wire [31:0] wr_data,
	// read port, data one cycle after the index
	input wire [IDX_W-1:0] rd_idx,
	output reg [31:0] rd_data
);

	// array has no reset; software loads it before use
	reg [31:0] mem [0:DEPTH-1];

	// write side
	always @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	// read side, old value returned on a same-cycle write
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= 32'h0000_0000;
		end else begin
			rd_data <= mem[rd_idx];
		end
	end

endmodule

// ---- design/hsu_store_unit.v ----
// Function
// - opcode 45: halfword store with update
// - opcode 31/439: indexed halfword store, update
// - opcode 31/407: plain indexed halfword store
// - store low halfword of source register
// - displacement sign-extended, added unless base zero
// - index plus base, or index alone
// - update base only if nonzero, no fault
// - exception and condition registers stay untouched
// - opcode 47: store multiple word decode
// - store registers first through 31, consecutive words
// - multiple store address: base plus displacement
// - unaligned multiple store result is implementation-defined
`timescale 1ns/100ps
`include "hsu_regs.vh"

module hsu_store_unit (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// instruction stream
	input wire instr_valid,
	input wire [31:0] instr_word,
	output reg instr_ready_reg,
	output reg done_reg,
	output reg illegal_reg,
	output reg fault_reg,
	output reg [1:0] fault_cause_reg,
	// register file load from the core
	input wire gpr_load_en,
	input wire [4:0] gpr_load_idx,
	input wire [31:0] gpr_load_data,
	// base register write-back report
	output reg gpr_upd_valid_reg,
	output reg [4:0] gpr_upd_idx_reg,
	output reg [31:0] gpr_upd_data_reg,
	// data memory port
	output reg mem_req_reg,
	output reg [31:0] mem_addr_reg,
	output reg [31:0] mem_wdata_reg,
	output reg [1:0] mem_size_reg,
	input wire mem_ack,
	input wire mem_align_err,
	input wire mem_dsi_err
);

	// sequencer states
	localparam S_IDLE = 3'h0;
	localparam S_BASE = 3'h1;
	localparam S_IDX = 3'h2;
	localparam S_SRC = 3'h3;
	localparam S_MEM = 3'h4;

	// instruction class from opcode fields
	function [2:0] hsu_decode;
		input [31:0] iw;
		begin
			hsu_decode = `HSU_CLS_NONE;
			if (iw[`HSU_F_OPCD] == `HSU_OP_STH_UPD) begin
				hsu_decode = `HSU_CLS_D_UPD;
			end else if (iw[`HSU_F_OPCD] == `HSU_OP_STM_WORD) begin
				hsu_decode = `HSU_CLS_MULT;
			end else if (iw[`HSU_F_OPCD] == `HSU_OP_EXT) begin
				if (iw[`HSU_F_XO] == `HSU_XO_STH_UPD_X) begin
					hsu_decode = `HSU_CLS_X_UPD;
				end else if (iw[`HSU_F_XO] == `HSU_XO_STH_X) begin
					hsu_decode = `HSU_CLS_X_PLAIN;
				end
			end
		end
	endfunction

	// base of zero means no base register at all
	function [31:0] hsu_ea;
		input [4:0] base_idx;
		input [31:0] base_val;
		input [31:0] offset;
		begin
			hsu_ea = (base_idx == 5'h00) ? offset : base_val + offset;
		end
	endfunction

	// sequencer and latched fields
	reg [2:0] state_reg, state_next;
	reg [2:0] cls_reg; // decoded class
	reg [4:0] base_idx_reg; // base register number
	reg [4:0] index_idx_reg; // index register number
	reg [4:0] src_idx_reg; // current source register
	reg [15:0] disp_reg; // raw displacement
	reg [31:0] base_val_reg; // base register contents
	reg [31:0] index_val_reg; // index register contents
	reg [31:0] ea_reg; // current effective address
	reg first_reg; // first word of the instruction

	// register file hookup
	reg [4:0] rd_idx;
	wire [31:0] rd_data;
	wire is_indexed;
	wire is_update;
	wire accept;
	wire mem_err;
	wire upd_fire;
	wire mult_more;
	wire [2:0] cls_in;
	wire [31:0] ea_first;
	wire gpr_wr_en;
	wire [4:0] gpr_wr_idx;
	wire [31:0] gpr_wr_data;

	assign cls_in = hsu_decode(instr_word);
	assign accept = (state_reg == S_IDLE) && instr_valid && instr_ready_reg &&
		(cls_in != `HSU_CLS_NONE);
	assign is_indexed = (cls_reg == `HSU_CLS_X_UPD) || (cls_reg == `HSU_CLS_X_PLAIN);
	assign is_update = (cls_reg == `HSU_CLS_D_UPD) || (cls_reg == `HSU_CLS_X_UPD);
	assign mem_err = mem_align_err || mem_dsi_err;
	// keep going until register 31 is stored
	assign mult_more = (cls_reg == `HSU_CLS_MULT) && (src_idx_reg != `HSU_LAST_REG);
	// write back only clean, nonzero-base update stores
	assign upd_fire = (state_reg == S_MEM) && mem_ack && !mem_err && is_update &&
		(base_idx_reg != 5'h00);

	// multiple store shares the displacement sum
	// indexed forms add the index register
	assign ea_first = hsu_ea(base_idx_reg, base_val_reg,
		is_indexed ? index_val_reg : {{16{disp_reg[15]}}, disp_reg});

	// update write wins; core loads only land while idle
	assign gpr_wr_en = upd_fire || (gpr_load_en && (state_reg == S_IDLE));
	assign gpr_wr_idx = upd_fire ? base_idx_reg : gpr_load_idx;
	assign gpr_wr_data = upd_fire ? ea_reg : gpr_load_data;

	// read index follows the sequencer one step ahead
	always @* begin
		case (state_reg)
			S_IDLE: rd_idx = instr_word[`HSU_F_BASE];
			S_BASE: rd_idx = is_indexed ? index_idx_reg : src_idx_reg;
			S_IDX: rd_idx = src_idx_reg;
			S_MEM: rd_idx = src_idx_reg + 5'h01;
			default: rd_idx = src_idx_reg;
		endcase
	end

	hsu_gpr_file #(
		.DEPTH(32),
		.IDX_W(5)
	) u_gpr (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.wr_en(gpr_wr_en),
		.wr_idx(gpr_wr_idx),
		.wr_data(gpr_wr_data),
		.rd_idx(rd_idx),
		.rd_data(rd_data)
	);

	// next state
	always @* begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (accept) begin
					state_next = S_BASE;
				end
			end
			S_BASE: begin
				state_next = is_indexed ? S_IDX : S_SRC;
			end
			S_IDX: begin
				state_next = S_SRC;
			end
			S_SRC: begin
				state_next = S_MEM;
			end
			S_MEM: begin
				// a fault ends a multiple store early
				if (mem_ack) begin
					state_next = (!mem_err && mult_more) ? S_SRC : S_IDLE;
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	// datapath and status registers
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= S_IDLE;
			cls_reg <= `HSU_CLS_NONE;
			base_idx_reg <= 5'h00;
			index_idx_reg <= 5'h00;
			src_idx_reg <= 5'h00;
			disp_reg <= 16'h0000;
			base_val_reg <= 32'h0000_0000;
			index_val_reg <= 32'h0000_0000;
			ea_reg <= 32'h0000_0000;
			first_reg <= 1'b0;
			instr_ready_reg <= 1'b0;
			done_reg <= 1'b0;
			illegal_reg <= 1'b0;
			fault_reg <= 1'b0;
			fault_cause_reg <= 2'h0;
			gpr_upd_valid_reg <= 1'b0;
			gpr_upd_idx_reg <= 5'h00;
			gpr_upd_data_reg <= 32'h0000_0000;
			mem_req_reg <= 1'b0;
			mem_addr_reg <= 32'h0000_0000;
			mem_wdata_reg <= 32'h0000_0000;
			mem_size_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			instr_ready_reg <= (state_next == S_IDLE);
			done_reg <= 1'b0;
			illegal_reg <= 1'b0;
			fault_reg <= 1'b0;
			gpr_upd_valid_reg <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					// unknown encodings are reported, not executed
					if (instr_valid && instr_ready_reg && (cls_in == `HSU_CLS_NONE)) begin
						illegal_reg <= 1'b1;
					end
					if (accept) begin
						cls_reg <= cls_in;
						src_idx_reg <= instr_word[`HSU_F_SRC];
						base_idx_reg <= instr_word[`HSU_F_BASE];
						index_idx_reg <= instr_word[`HSU_F_INDEX];
						disp_reg <= instr_word[`HSU_F_DISP];
						first_reg <= 1'b1;
					end
				end
				S_BASE: begin
					base_val_reg <= rd_data;
				end
				S_IDX: begin
					index_val_reg <= rd_data;
				end
				S_SRC: begin
					// later words of a multiple store reuse ea_reg
					mem_req_reg <= 1'b1;
					first_reg <= 1'b0;
					if (first_reg) begin
						ea_reg <= ea_first;
						mem_addr_reg <= ea_first;
					end else begin
						mem_addr_reg <= ea_reg;
					end
					if (cls_reg == `HSU_CLS_MULT) begin
						mem_size_reg <= `HSU_SIZE_WORD;
						mem_wdata_reg <= rd_data;
					end else begin
						// only bits 16-31 of the source travel
						// memory puts bits 16-23 at the lower byte
						mem_size_reg <= `HSU_SIZE_HALF;
						mem_wdata_reg <= {16'h0000, rd_data[`HSU_F_HALF]};
					end
				end
				S_MEM: begin
					if (mem_ack) begin
						mem_req_reg <= 1'b0;
						if (mem_err) begin
							fault_reg <= 1'b1;
							fault_cause_reg <= (mem_align_err ? `HSU_FAULT_ALIGN : 2'h0) |
								(mem_dsi_err ? `HSU_FAULT_DSI : 2'h0);
						end else if (mult_more) begin
							src_idx_reg <= src_idx_reg + 5'h01;
							ea_reg <= ea_reg + `HSU_WORD_STEP;
						end else begin
							done_reg <= 1'b1;
						end
						if (upd_fire) begin
							gpr_upd_valid_reg <= 1'b1;
							gpr_upd_idx_reg <= base_idx_reg;
							gpr_upd_data_reg <= ea_reg;
						end
					end
				end
				default: begin
					mem_req_reg <= 1'b0;
				end
			endcase
		end
	end

endmodule

// ---- testbench/hsu_store_unit_properties.sv ----
`timescale 1ns/100ps
// port-level checks of the store unit
module hsu_store_unit_properties (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// instruction side
	input wire instr_valid,
	input wire [31:0] instr_word,
	input wire instr_ready_reg,
	input wire done_reg,
	input wire illegal_reg,
	input wire fault_reg,
	input wire [1:0] fault_cause_reg,
	input wire gpr_upd_valid_reg,
	input wire [4:0] gpr_upd_idx_reg,
	// memory side
	input wire mem_req_reg,
	input wire [31:0] mem_addr_reg,
	input wire [31:0] mem_wdata_reg,
	input wire [1:0] mem_size_reg,
	input wire mem_ack,
	input wire mem_align_err,
	input wire mem_dsi_err
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// accepted instruction and its opcode fields
	wire take = instr_valid && instr_ready_reg;
	wire [5:0] opc = instr_word[31:26];
	wire [9:0] xop = instr_word[10:1];
	property p_hold;
		mem_req_reg && !mem_ack |=> mem_req_reg && $stable(mem_addr_reg) && $stable(mem_wdata_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("store request moved before ack");
	property p_drop;
		mem_req_reg && mem_ack |=> !mem_req_reg;
	endproperty
	a_drop: assert property (p_drop) else $error("request kept after ack");
	property p_half;
		mem_req_reg && mem_size_reg == 2'h1 |-> mem_wdata_reg[31:16] == 16'h0000;
	endproperty
	a_half: assert property (p_half) else $error("halfword upper bits set");
	property p_upd;
		gpr_upd_valid_reg |-> gpr_upd_idx_reg != 5'h00 && done_reg;
	endproperty
	a_upd: assert property (p_upd) else $error("base update without clean finish");
	property p_fault;
		mem_req_reg && mem_ack && (mem_align_err || mem_dsi_err) |=> fault_reg && !done_reg
			&& !gpr_upd_valid_reg && fault_cause_reg == {$past(mem_dsi_err), $past(mem_align_err)};
	endproperty
	a_fault: assert property (p_fault) else $error("memory error not reported");
	property p_dform;
		take && opc == 6'h2d |=> !instr_ready_reg ##2 mem_req_reg && mem_size_reg == 2'h1;
	endproperty
	a_dform: assert property (p_dform) else $error("displacement store timing");
	property p_xform;
		take && opc == 6'h1f && xop == 10'h197 |=> !mem_req_reg [*3] ##1 mem_req_reg;
	endproperty
	a_xform: assert property (p_xform) else $error("indexed store timing");
	property p_step;
		(mem_req_reg && mem_ack && mem_size_reg == 2'h2) ##2 mem_req_reg
			|-> mem_addr_reg == $past(mem_addr_reg, 2) + 32'h0000_0004;
	endproperty
	a_step: assert property (p_step) else $error("multiple store word stride");
	property p_illegal;
		take && opc == 6'h1f && xop == 10'h396 |=> illegal_reg && instr_ready_reg;
	endproperty
	a_illegal: assert property (p_illegal) else $error("foreign extended opcode taken");
	// indexed update form takes the extra index read, then a halfword request
	property p_xupd;
		take && opc == 6'h1f && xop == 10'h1b7
			|=> !mem_req_reg [*3] ##1 mem_req_reg && mem_size_reg == 2'h1;
	endproperty
	a_xupd: assert property (p_xupd) else $error("indexed update store timing");
	// multiple store issues word-sized requests on the displacement timing
	property p_mform;
		take && opc == 6'h2f |=> !instr_ready_reg ##2 mem_req_reg && mem_size_reg == 2'h2;
	endproperty
	a_mform: assert property (p_mform) else $error("multiple store timing");
	// nothing finishes, faults or writes back without an answered request
	property p_noack;
		!(mem_req_reg && mem_ack) |=> !fault_reg && !done_reg && !gpr_upd_valid_reg;
	endproperty
	a_noack: assert property (p_noack) else $error("result without memory answer");
endmodule

bind hsu_store_unit hsu_store_unit_properties hsu_store_unit_properties_inst (.core_clk,
	.reset_n, .instr_valid, .instr_word, .instr_ready_reg, .done_reg, .illegal_reg, .fault_reg,
	.fault_cause_reg, .gpr_upd_valid_reg, .gpr_upd_idx_reg, .mem_req_reg, .mem_addr_reg,
	.mem_wdata_reg, .mem_size_reg, .mem_ack, .mem_align_err, .mem_dsi_err);

// ---- testbench/hsu_mem_model.sv ----
`timescale 1ns/100ps
// data memory end: acks at once or after a stall
module hsu_mem_model (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// store port
	input wire mem_req_reg,
	output reg mem_ack,
	output wire mem_align_err,
	output wire mem_dsi_err,
	// bench controls
	input wire slow,
	input wire [1:0] err_code
);
	reg [1:0] wait_reg; // cycles the request has waited
	// one-cycle ack, never before the stall runs out
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_ack <= 1'b0;
			wait_reg <= 2'h0;
		end else begin
			mem_ack <= mem_req_reg && !mem_ack && (!slow || wait_reg == 2'h3);
			wait_reg <= (mem_req_reg && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
		end
	end
	// error lines mean nothing without ack, so they toggle to catch misuse
	assign mem_align_err = mem_ack ? err_code[0] : wait_reg[0];
	assign mem_dsi_err = mem_ack ? err_code[1] : ~wait_reg[0];
endmodule

// ---- testbench/tb_hsu_store_unit.sv ----
`timescale 1ns/100ps
// store mix against a queue model of the expected memory writes
module tb_hsu_store_unit;
	reg core_clk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, gpr_load_en = 1'b0, slow = 1'b0;
	reg [31:0] instr_word = 32'h0000_0000, gpr_load_data = 32'h0000_0000;
	reg [4:0] gpr_load_idx = 5'h00;
	reg [1:0] err_code = 2'h0;
	wire instr_ready_reg, done_reg, illegal_reg, fault_reg, gpr_upd_valid_reg, mem_req_reg;
	wire mem_ack, mem_align_err, mem_dsi_err;
	wire [1:0] fault_cause_reg, mem_size_reg;
	wire [4:0] gpr_upd_idx_reg;
	wire [31:0] gpr_upd_data_reg, mem_addr_reg, mem_wdata_reg;
	logic [31:0] gpr [32]; // shadow register file
	logic [65:0] q [$]; // expected {size, address, data}
	logic [31:0] rnd = 32'h1ae6, iw, bv;
	logic [4:0] ra;
	logic [1:0] lastc = 2'h0;
	int num_errors = 0, checks = 0, cyc = 0, i;
	hsu_store_unit hsu_store_unit_inst (.core_clk, .reset_n, .instr_valid, .instr_word,
		.instr_ready_reg, .done_reg, .illegal_reg, .fault_reg, .fault_cause_reg, .gpr_load_en,
		.gpr_load_idx, .gpr_load_data, .gpr_upd_valid_reg, .gpr_upd_idx_reg, .gpr_upd_data_reg,
		.mem_req_reg, .mem_addr_reg, .mem_wdata_reg, .mem_size_reg, .mem_ack, .mem_align_err,
		.mem_dsi_err);
	hsu_mem_model hsu_mem_model_inst (.core_clk, .reset_n, .mem_req_reg, .mem_ack,
		.mem_align_err, .mem_dsi_err, .slow, .err_code);
	always #5 core_clk = ~core_clk;
	// hang guard, far above the longest mix
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors = num_errors + 1;
			finish_test;
		end
	end
	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input [71:0] g, input [71:0] e);
		checks = checks + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task finish_test;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// one instruction: predict, offer, then watch every result
	task run(input [31:0] w, input [1:0] ec);
		logic [31:0] ea;
		logic [5:0] op;
		logic ok, upd, fin, seen;
		int k;
		op = w[31:26];
		bv = (w[20:16] != 5'h00) ? gpr[w[20:16]] : 32'h0000_0000;
		ea = bv + ((op == 6'h1f) ? gpr[w[15:11]] : {{16{w[15]}}, w[15:0]});
		ok = op == 6'h2d || op == 6'h2f || (op == 6'h1f && (w[10:1] == 10'h1b7 || w[10:1] == 10'h197));
		upd = (op == 6'h2d || (op == 6'h1f && w[10:1] == 10'h1b7)) && w[20:16] != 5'h00 && ec == 2'h0;
		if (op == 6'h2f)
			for (k = w[25:21]; k < 32 && (k == w[25:21] || ec == 2'h0); k++)
				q.push_back({2'h2, ea + 32'(4 * (k - w[25:21])), gpr[k]});
		else if (ok)
			q.push_back({2'h1, ea, 16'h0000, gpr[w[25:21]][15:0]});
		if (ok && ec != 2'h0)
			lastc = ec;
		chk(instr_ready_reg, 1'b1);
		instr_word = w;
		err_code = ec;
		slow = rnd[31];
		instr_valid = 1'b1;
		@(negedge core_clk);
		instr_valid = 1'b0;
		fin = 1'b0;
		seen = 1'b0;
		for (k = 0; k < 400 && !fin; k++) begin
			if ((mem_req_reg && mem_ack) === 1'b1)
				chk({mem_size_reg, mem_addr_reg, mem_wdata_reg}, q.size() ? q.pop_front() : 66'h0);
			if (gpr_upd_valid_reg === 1'b1) begin
				chk({gpr_upd_idx_reg, gpr_upd_data_reg}, {w[20:16], ea});
				seen = 1'b1;
			end
			if ((done_reg | fault_reg | illegal_reg) === 1'b1) begin
				chk({illegal_reg, fault_reg, done_reg, fault_cause_reg}, {!ok, ok && ec != 0, ok && ec == 0, lastc});
				fin = 1'b1;
			end else
				@(negedge core_clk);
		end
		chk({fin, seen, 7'(q.size())}, {1'b1, upd, 7'h00});
		q.delete();
		if (upd)
			gpr[w[20:16]] = ea;
	endtask
	initial begin
		repeat (5) @(negedge core_clk);
		reset_n = 1'b1;
		@(negedge core_clk);
		for (i = 0; i < 32; i++) begin
			rnd = lfsr(rnd);
			gpr_load_en = 1'b1;
			gpr_load_idx = i[4:0];
			gpr_load_data = rnd;
			gpr[i] = rnd;
			@(negedge core_clk);
		end
		gpr_load_en = 1'b0;
		// first six use base field zero, except the illegal encoding at i == 4, then random bases
		for (i = 0; i < 30; i++) begin
			rnd = lfsr(rnd);
			ra = (i < 6) ? 5'h00 : rnd[20:16];
			bv = (ra != 5'h00) ? gpr[ra] : 32'h0000_0000;
			case (i % 6)
				1: iw = {6'h1f, rnd[25:21], ra, rnd[15:11], 10'h1b7, 1'b0};
				2: iw = {6'h1f, rnd[25:21], ra, rnd[15:11], 10'h197, 1'b0};
				// word-aligned start keeps the multiple store defined
				3: iw = {6'h2f, (i == 3) ? 5'h1f : rnd[25:21], ra, {rnd[15:2], 2'b00} - 16'(bv[1:0])};
				4: iw = {6'h1f, rnd[25:11], 10'h396, 1'b0};
				default: iw = {6'h2d, rnd[25:21], ra, rnd[15:0]};
			endcase
			// error mix covers align, storage and both; one multiple store faults too
			run(iw, (i % 6 == 5 || i == 27) ? {i[3] | i[4], ~i[3]} : 2'h0);
			$display("test %0d done", i);
		end
		finish_test;
	end
endmodule
